// ---- rtl/irq_ctrl_consts.svh ----
// Register indices, field positions, reset values and counts
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (APB byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_KEY_ENABLE      16'hFF23
`define IDX_TMR_SER_EN      16'hFF24
`define IDX_CLK_DSP_EN      16'hFF25
`define IDX_KEY_FLAGS       16'hFF27
`define IDX_TMR_SER_FLAGS   16'hFF28
`define IDX_CLK_DSP_FLAGS   16'hFF29
`define IDX_WDT_CTRL        16'hFF53
`define IDX_KEY_LOW_SEL     16'hFFC0
`define IDX_KEY_LOW_POL     16'hFFC1
`define IDX_KEY_HIGH_POL    16'hFFC2

// ----------------------------------------------------------------
// Implemented bit masks (other bits read zero)
// ----------------------------------------------------------------
`define TS_MASK             8'hFF
`define CD_MASK             8'hFC
`define KEY_MASK            8'hF8
`define WDT_READ_MASK       8'hE0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WDT_UNLOCK_BIT      7
`define WDT_NMI_EN_BIT      6
`define WDT_CLK_SEL_BIT     5
`define WDT_CLEAR_BIT       0

// ----------------------------------------------------------------
// Reset values and watchdog counts
// ----------------------------------------------------------------
`define WDT_NMI_EN_RST      1'b1
`define WDT_CLK_SEL_RST     1'b0
`define KEY_LOW_SEL_RST     8'h00
`define KEY_LOW_POL_RST     8'hFF
`define KEY_HIGH_POL_RST    4'hF
`define WDT_PRE_MAX         4'hF
`define WDT_CNT_W           8
`define WDT_CNT_MAX         8'hFF

`endif

// ---- rtl/irq_ctrl_pkg.sv ----
// Types shared by the interrupt control block
`include "irq_ctrl_consts.svh"

package irq_ctrl_pkg;

	typedef logic [7:0] byte_t;

	// State of the key edge detector
	typedef struct packed {
		logic [11:0] prev;
		logic        primed;
	} key_state_s;

	// State of the main controller
	typedef struct packed {
		byte_t                 tsFlags;
		byte_t                 cdFlags;
		byte_t                 keyFlags;
		byte_t                 tsEn;
		byte_t                 cdEn;
		byte_t                 keyEn;
		logic                  wdUnlock;
		logic                  wdNmiEn;
		logic                  wdClkSel;
		logic [3:0]            wdPre;
		logic [`WDT_CNT_W-1:0] wdCnt;
		byte_t                 keySel;
		byte_t                 keyPolLow;
		logic [3:0]            keyPolHigh;
		logic [31:0]           prdata;
		logic                  pready;
		logic                  pslverr;
		logic                  irqReq;
		logic                  nmiReq;
	} ctrl_state_s;

endpackage : irq_ctrl_pkg

// ---- rtl/key_edge_detect.sv ----
// Edge detector for the twelve key input lines
`timescale 1ns/1ns
`default_nettype none

module key_edge_detect
	import irq_ctrl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [11:0] keyIn,
	input  wire logic [11:0] polarity,
	output var  logic [11:0] edgeHit
);
	import irq_ctrl_pkg::*;

	key_state_s st_ff;
	key_state_s nxt_st;

	// ----------------------------------------------------------------
	// Edge selection
	// ----------------------------------------------------------------
	// R18 R19 polarity picks edge
	// Polarity 1 keeps falling edges, 0 keeps rising edges
	always_comb
	begin
		edgeHit = {12{st_ff.primed}} & (st_ff.prev ^ keyIn) &
			(polarity ^ keyIn);
	end

	// First sample after reset only primes history, no false edge
	always_comb
	begin
		nxt_st        = st_ff;
		nxt_st.prev   = keyIn;
		nxt_st.primed = 1'b1;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_fall_edge;
		@(posedge clk) disable iff (!arst_n)
		(st_ff.primed && polarity[8] && st_ff.prev[8] && !keyIn[8])
			|-> edgeHit[8];
	endproperty
	a_fall_edge: assert property (p_fall_edge) // R19
		else $error("falling edge on upper line 0 missed");

endmodule : key_edge_detect

`default_nettype wire

// ---- rtl/irq_flags_wdt_keyint_ctrl.sv ----
// Interrupt flags, watchdog control and key interrupt control
//
// Summary of operation
// R1: Timer underflow flags sit at bits 7, 5, 3 of first flag register.
// R2: Wide timer compare flags sit at bits 6 and 4; zero after reset.
// R3: Serial transmit done latches into bit 2 of first flag register.
// R4: Serial receive done latches into bit 1 of first flag register.
// R5: Serial receive error latches into bit 0 of first flag register.
// R6: Minute tick latches into bit 7 of second flag register.
// R7: 1, 2, 8 and 32 Hz ticks latch into bits 6 to 3.
// R8: Display event latches into bit 2 of second flag register.
// R9: Writing one clears a flag; writing zero leaves it alone.
// R10: Maskable request raised while any flag and its enable are set.
// R11: NMI enable and clock select writes need the unlock bit first.
// R12: Unlock bit drops back to zero after a protected write.
// R13: Watchdog overflow raises NMI only while NMI enable is one.
// R14: Clock select one uses fast oscillator /16, zero slow /16.
// R15: Writing one to watchdog bit 0 clears the watchdog counter.
// R16: Watchdog keeps counting while NMI enable is zero.
// R17: Lower key lines join grouped interrupt only when selected.
// R18: Lower key polarity one means falling edge, zero rising.
// R19: Upper key polarity bits 3 to 0, one falling, zero rising.
// R20: Unused bits read zero and ignore writes.
// R21: Flags set on event pulses; a set beats a same-cycle clear.
`timescale 1ns/1ns
`default_nettype none

module irq_flags_wdt_keyint_ctrl
	import irq_ctrl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [17:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic [7:0]  timerSerialEvt,
	input  wire logic [5:0]  clockDisplayEvt,
	input  wire logic [7:0]  keyLow,
	input  wire logic [3:0]  keyHigh,
	input  wire logic        fastOscTick,
	input  wire logic        slowOscTick,
	output var  logic        irqReq,
	output var  logic        nmiReq
);
	import irq_ctrl_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	ctrl_state_s st_ff;
	ctrl_state_s nxt_st;
	logic [15:0] regIdx;
	logic        wrAcc;
	logic        rdSetup;
	byte_t       wrByte;
	logic [11:0] edgeHit;
	logic        keyGroupHit;
	byte_t       evtTs;
	byte_t       evtCd;
	byte_t       evtKey;
	logic        wdWrite;
	logic        wdClear;
	logic        wdTick;
	logic        wdPreWrap;
	logic        wdOverflow;
	logic        hitKeyEn;
	logic        hitTsEn;
	logic        hitCdEn;
	logic        hitKeyFlags;
	logic        hitTsFlags;
	logic        hitCdFlags;
	logic        hitKeySel;
	logic        hitKeyPolLow;
	logic        hitKeyPolHigh;
	logic        mapped;
	byte_t       rdByte;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Flag update shared by all three flag registers
	function automatic byte_t flag_next(
		input byte_t cur,
		input byte_t evt,
		input byte_t wdat,
		input logic  hit,
		input byte_t mask
	);
		byte_t clr;
		clr = hit ? wdat : 8'h00;
		flag_next = ((cur & ~clr) | evt) & mask;
	endfunction : flag_next

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// One wait-free access: setup cycle computes, access cycle answers
	assign regIdx  = paddr[17:2];
	assign wrByte  = pwdata[7:0];
	assign wrAcc   = psel & penable & pwrite & st_ff.pready;
	assign rdSetup = psel & ~penable;

	assign hitKeyEn      = regIdx == `IDX_KEY_ENABLE;
	assign hitTsEn       = regIdx == `IDX_TMR_SER_EN;
	assign hitCdEn       = regIdx == `IDX_CLK_DSP_EN;
	assign hitKeyFlags   = regIdx == `IDX_KEY_FLAGS;
	assign hitTsFlags    = regIdx == `IDX_TMR_SER_FLAGS;
	assign hitCdFlags    = regIdx == `IDX_CLK_DSP_FLAGS;
	assign wdWrite       = wrAcc & (regIdx == `IDX_WDT_CTRL);
	assign hitKeySel     = regIdx == `IDX_KEY_LOW_SEL;
	assign hitKeyPolLow  = regIdx == `IDX_KEY_LOW_POL;
	assign hitKeyPolHigh = regIdx == `IDX_KEY_HIGH_POL;
	assign mapped = hitKeyEn | hitTsEn | hitCdEn | hitKeyFlags |
		hitTsFlags | hitCdFlags | (regIdx == `IDX_WDT_CTRL) |
		hitKeySel | hitKeyPolLow | hitKeyPolHigh;

	// ----------------------------------------------------------------
	// Key edge detection
	// ----------------------------------------------------------------
	key_edge_detect u_keyEdge (
		.clk      (clk),
		.arst_n   (arst_n),
		.keyIn    ({keyHigh, keyLow}),
		.polarity ({st_ff.keyPolHigh, st_ff.keyPolLow}),
		.edgeHit  (edgeHit)
	);

	// R17 select gates lines
	// Only selected lower lines feed the grouped key flag
	assign keyGroupHit = |(edgeHit[7:0] & st_ff.keySel);

	// ----------------------------------------------------------------
	// Event vectors
	// ----------------------------------------------------------------
	// R1 R2 R3 R4 R5 timer serial events
	// Event bits land on the flag positions one to one
	assign evtTs  = timerSerialEvt;
	// R6 R7 R8 clock display events
	assign evtCd  = {clockDisplayEvt, 2'b00};
	assign evtKey = {edgeHit[11:8], keyGroupHit, 3'b000};

	// ----------------------------------------------------------------
	// Watchdog timebase
	// ----------------------------------------------------------------
	// R14 clock source select
	assign wdTick = st_ff.wdClkSel ? fastOscTick : slowOscTick;
	// R15 counter clear strobe
	assign wdClear = wdWrite & wrByte[`WDT_CLEAR_BIT];
	assign wdPreWrap = wdTick & (st_ff.wdPre == `WDT_PRE_MAX);
	// Clear beats a coincident overflow so software always wins
	assign wdOverflow = wdPreWrap & (st_ff.wdCnt == `WDT_CNT_MAX) &
		~wdClear;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// R20 unused bits zero
	always_comb
	begin
		rdByte = 8'h00;
		unique case (1'b1)
			hitKeyEn:      rdByte = st_ff.keyEn & `KEY_MASK;
			hitTsEn:       rdByte = st_ff.tsEn;
			hitCdEn:       rdByte = st_ff.cdEn & `CD_MASK;
			hitKeyFlags:   rdByte = st_ff.keyFlags;
			hitTsFlags:    rdByte = st_ff.tsFlags;
			hitCdFlags:    rdByte = st_ff.cdFlags;
			hitKeySel:     rdByte = st_ff.keySel;
			hitKeyPolLow:  rdByte = st_ff.keyPolLow;
			hitKeyPolHigh: rdByte = {4'h0, st_ff.keyPolHigh};
			default:
			begin
				if (regIdx == `IDX_WDT_CTRL)
					rdByte = {st_ff.wdUnlock, st_ff.wdNmiEn,
						st_ff.wdClkSel, 5'h00};
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_st = st_ff;

		// Bus answer: ready in the access cycle, error if unmapped
		nxt_st.pready  = rdSetup;
		nxt_st.pslverr = rdSetup & ~mapped;
		if (rdSetup)
			nxt_st.prdata = {24'h000000, rdByte};

		// R9 R21 write one clears, set wins
		nxt_st.tsFlags  = flag_next(st_ff.tsFlags, evtTs, wrByte,
			wrAcc & hitTsFlags, `TS_MASK);
		nxt_st.cdFlags  = flag_next(st_ff.cdFlags, evtCd, wrByte,
			wrAcc & hitCdFlags, `CD_MASK);
		nxt_st.keyFlags = flag_next(st_ff.keyFlags, evtKey, wrByte,
			wrAcc & hitKeyFlags, `KEY_MASK);

		// Plain read/write control registers
		if (wrAcc & hitKeyEn)
			nxt_st.keyEn = wrByte & `KEY_MASK;
		if (wrAcc & hitTsEn)
			nxt_st.tsEn = wrByte;
		if (wrAcc & hitCdEn)
			nxt_st.cdEn = wrByte & `CD_MASK;
		if (wrAcc & hitKeySel)
			nxt_st.keySel = wrByte;
		// R18 lower polarity write
		if (wrAcc & hitKeyPolLow)
			nxt_st.keyPolLow = wrByte;
		// R19 upper polarity write
		if (wrAcc & hitKeyPolHigh)
			nxt_st.keyPolHigh = wrByte[3:0];

		// R11 R12 protected watchdog fields
		if (wdWrite)
		begin
			if (st_ff.wdUnlock)
			begin
				nxt_st.wdNmiEn  = wrByte[`WDT_NMI_EN_BIT];
				nxt_st.wdClkSel = wrByte[`WDT_CLK_SEL_BIT];
				nxt_st.wdUnlock = 1'b0;
			end
			else
				nxt_st.wdUnlock = wrByte[`WDT_UNLOCK_BIT];
		end

		// R15 R16 counting regardless of enable
		if (wdClear)
		begin
			nxt_st.wdPre = 4'h0;
			nxt_st.wdCnt = '0;
		end
		else if (wdTick)
		begin
			nxt_st.wdPre = st_ff.wdPre + 4'h1;
			if (wdPreWrap)
				nxt_st.wdCnt = st_ff.wdCnt + `WDT_CNT_W'(1);
		end

		// R13 NMI gated by enable
		nxt_st.nmiReq = wdOverflow & st_ff.wdNmiEn;

		// R10 flag and enable pairs
		nxt_st.irqReq = |((nxt_st.tsFlags & nxt_st.tsEn) |
			(nxt_st.cdFlags & nxt_st.cdEn) |
			(nxt_st.keyFlags & nxt_st.keyEn));
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_ff            <= '0;
			st_ff.wdNmiEn    <= `WDT_NMI_EN_RST;
			st_ff.wdClkSel   <= `WDT_CLK_SEL_RST;
			st_ff.keySel     <= `KEY_LOW_SEL_RST;
			st_ff.keyPolLow  <= `KEY_LOW_POL_RST;
			st_ff.keyPolHigh <= `KEY_HIGH_POL_RST;
		end
		else
			st_ff <= nxt_st;
	end

	// Outputs straight from the state flops
	assign prdata  = st_ff.prdata;
	assign pready  = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign irqReq  = st_ff.irqReq;
	assign nmiReq  = st_ff.nmiReq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_locked_wd_write;
		wdWrite && !st_ff.wdUnlock;
	endsequence

	sequence s_unlocked_wd_write;
		wdWrite && st_ff.wdUnlock;
	endsequence

	property p_set_wins;
		@(posedge clk) disable iff (!arst_n)
		(evtTs[6] && wrAcc && hitTsFlags && wrByte[6])
			|=> st_ff.tsFlags[6];
	endproperty
	a_set_wins: assert property (p_set_wins) // R21
		else $error("event lost against clear");

	property p_w1c;
		@(posedge clk) disable iff (!arst_n)
		(wrAcc && hitCdFlags && wrByte[7] && !evtCd[7])
			|=> !st_ff.cdFlags[7];
	endproperty
	a_w1c: assert property (p_w1c) // R9
		else $error("write one did not clear flag");

	property p_w0_keeps;
		@(posedge clk) disable iff (!arst_n)
		(wrAcc && hitTsFlags && !wrByte[5] && st_ff.tsFlags[5])
			|=> st_ff.tsFlags[5];
	endproperty
	a_w0_keeps: assert property (p_w0_keeps) // R9
		else $error("write zero cleared flag");

	property p_irq_gate;
		@(posedge clk) disable iff (!arst_n)
		irqReq == |((st_ff.tsFlags & st_ff.tsEn) |
			(st_ff.cdFlags & st_ff.cdEn) |
			(st_ff.keyFlags & st_ff.keyEn));
	endproperty
	a_irq_gate: assert property (p_irq_gate) // R10
		else $error("irq request not flag and enable");

	property p_locked_ignored;
		@(posedge clk) disable iff (!arst_n)
		s_locked_wd_write |=> $stable(st_ff.wdNmiEn) &&
			$stable(st_ff.wdClkSel);
	endproperty
	a_locked_ignored: assert property (p_locked_ignored) // R11
		else $error("protected bit changed while locked");

	property p_relock;
		@(posedge clk) disable iff (!arst_n)
		s_unlocked_wd_write |=> !st_ff.wdUnlock &&
			st_ff.wdNmiEn == $past(wrByte[`WDT_NMI_EN_BIT]);
	endproperty
	a_relock: assert property (p_relock) // R12
		else $error("unlock not cleared after write");

	property p_nmi_gate;
		@(posedge clk) disable iff (!arst_n)
		nmiReq |-> $past(st_ff.wdNmiEn) && $past(wdOverflow);
	endproperty
	a_nmi_gate: assert property (p_nmi_gate) // R13
		else $error("nmi without enable or overflow");

	property p_wd_clear;
		@(posedge clk) disable iff (!arst_n)
		wdClear |=> st_ff.wdCnt == '0 && st_ff.wdPre == 4'h0;
	endproperty
	a_wd_clear: assert property (p_wd_clear) // R15
		else $error("watchdog clear ignored");

	property p_count_disabled;
		@(posedge clk) disable iff (!arst_n)
		(!st_ff.wdNmiEn && wdTick && !wdClear && !wdWrite)
			|=> st_ff.wdPre == $past(st_ff.wdPre) + 4'h1;
	endproperty
	a_count_disabled: assert property (p_count_disabled) // R16
		else $error("watchdog stopped while disabled");

	property p_unused_zero;
		@(posedge clk) disable iff (!arst_n)
		(rdSetup && hitCdFlags) |=> prdata[1:0] == 2'b00 && pready;
	endproperty
	a_unused_zero: assert property (p_unused_zero) // R20
		else $error("unused flag bits read nonzero");

endmodule : irq_flags_wdt_keyint_ctrl

`default_nettype wire

// ---- verif/cpu_irq_sink.sv ----
// CPU side model that receives the non-maskable request
`timescale 1ns/1ns
`default_nettype none

module cpu_irq_sink
(
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic nmiReq,
	output var  int   nmiCount
);
	// Count NMI pulses; one high cycle is one request, so no edge detect
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			nmiCount <= 0;
		else if (nmiReq === 1'b1)
			nmiCount <= nmiCount + 1;
	end
endmodule : cpu_irq_sink

`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the flag, watchdog and key interrupt block
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctrl_consts.svh"

module testbench;
	import irq_ctrl_pkg::*;

	logic        clk;
	logic        arst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [17:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  timerSerialEvt;
	logic [5:0]  clockDisplayEvt;
	logic [7:0]  keyLow;
	logic [3:0]  keyHigh;
	logic        fastOscTick;
	logic        slowOscTick;
	logic        irqReq;
	logic        nmiReq;
	int          nmiCount;
	int          nErrors;
	int          totalChecks;
	byte_t       evtOnWrite;
	byte_t       rd;
	logic        err;
	logic [15:0] rstIdx [6];
	byte_t       rstVal [6];

	irq_flags_wdt_keyint_ctrl dut_u (.clk(clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timerSerialEvt(timerSerialEvt), .clockDisplayEvt(clockDisplayEvt),
		.keyLow(keyLow), .keyHigh(keyHigh), .fastOscTick(fastOscTick),
		.slowOscTick(slowOscTick), .irqReq(irqReq), .nmiReq(nmiReq));

	cpu_irq_sink cpu_u (.clk(clk), .arst_n(arst_n), .nmiReq(nmiReq),
		.nmiCount(nmiCount));

	// ------------------------------------------------------------
	// Clock, verdict and watchdog
	// ------------------------------------------------------------
	always #25 clk = ~clk;

	task automatic wrapUp();
		if (nErrors == 0 && totalChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrapUp

	// Whole run needs about 17k cycles; a hang is cut well beyond that
	initial
	begin
		repeat (60000) @(posedge clk);
		nErrors++;
		wrapUp();
	end

	// ------------------------------------------------------------
	// Bus, stimulus and compare tasks
	// ------------------------------------------------------------
	// One APB transfer; an optional event pulse lands on the taking edge
	task automatic apb(input logic wr, input logic [15:0] idx, input byte_t wd);
		int n;
		n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h000000, wd};
		@(posedge clk);
		penable        <= 1'b1;
		timerSerialEvt <= evtOnWrite;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd  = prdata[7:0];
		err = pslverr;
		psel           <= 1'b0;
		penable        <= 1'b0;
		timerSerialEvt <= 8'h00;
		if (n >= 16)
			nErrors++;
	endtask : apb

	task automatic chk(input string name, input byte_t exp, input byte_t got);
		totalChecks++;
		if (got !== exp)
		begin
			nErrors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic rdChk(input string name, input logic [15:0] idx,
		input byte_t exp);
		apb(1'b0, idx, 8'h00);
		chk(name, exp, rd);
	endtask : rdChk

	task automatic pulse(input byte_t ts, input logic [5:0] cd);
		@(posedge clk);
		timerSerialEvt  <= ts;
		clockDisplayEvt <= cd;
		@(posedge clk);
		timerSerialEvt  <= 8'h00;
		clockDisplayEvt <= 6'h00;
	endtask : pulse

	// Oscillator ticks, one per cycle, then a settle wait for the NMI
	task automatic tick(input logic fast, input int n);
		repeat (n)
		begin
			@(posedge clk);
			fastOscTick <= fast;
			slowOscTick <= !fast;
		end
		@(posedge clk);
		fastOscTick <= 1'b0;
		slowOscTick <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : tick

	// Key change; flag lands one edge later, one more for registered read
	task automatic keySet(input byte_t lo, input logic [3:0] hi);
		@(posedge clk);
		keyLow  <= lo;
		keyHigh <= hi;
		repeat (3) @(posedge clk);
	endtask : keySet

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 18'h00000;
		pwdata = 32'h00000000;
		timerSerialEvt = 8'h00;
		clockDisplayEvt = 6'h00;
		keyLow = 8'h00;
		keyHigh = 4'hF;
		fastOscTick = 1'b0;
		slowOscTick = 1'b0;
		evtOnWrite = 8'h00;
		nErrors = 0;
		totalChecks = 0;
		rstIdx = '{`IDX_TMR_SER_FLAGS, `IDX_CLK_DSP_FLAGS, `IDX_WDT_CTRL,
			`IDX_KEY_LOW_SEL, `IDX_KEY_LOW_POL, `IDX_KEY_HIGH_POL};
		rstVal = '{8'h00, 8'h00, 8'h40, 8'h00, 8'hFF, 8'h0F};
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		foreach (rstIdx[i])
			rdChk("reset value", rstIdx[i], rstVal[i]);
		// Flags latch, clear by one, and gate the maskable request
		pulse(8'hFF, 6'h3F);
		rdChk("ts flags", `IDX_TMR_SER_FLAGS, 8'hFF);
		rdChk("cd flags", `IDX_CLK_DSP_FLAGS, 8'hFC);
		chk("irq masked", 8'h00, {7'h00, irqReq});
		apb(1'b1, `IDX_TMR_SER_EN, 8'h80);
		repeat (2) @(posedge clk);
		chk("irq enabled", 8'h01, {7'h00, irqReq});
		apb(1'b1, `IDX_TMR_SER_FLAGS, 8'h0F);
		rdChk("ts partial clear", `IDX_TMR_SER_FLAGS, 8'hF0);
		evtOnWrite = 8'h40;
		apb(1'b1, `IDX_TMR_SER_FLAGS, 8'h40);
		evtOnWrite = 8'h00;
		rdChk("set beats clear", `IDX_TMR_SER_FLAGS, 8'hF0);
		apb(1'b1, `IDX_TMR_SER_FLAGS, 8'h80);
		repeat (2) @(posedge clk);
		chk("irq cleared", 8'h00, {7'h00, irqReq});
		apb(1'b1, `IDX_CLK_DSP_FLAGS, 8'hFF);
		rdChk("cd cleared", `IDX_CLK_DSP_FLAGS, 8'h00);
		// Minute and display events alone pin down the outer bit positions
		pulse(8'h00, 6'h21);
		rdChk("cd map", `IDX_CLK_DSP_FLAGS, 8'h84);
		apb(1'b0, 16'hFF30, 8'h00);
		chk("unmapped err", 8'h01, {7'h00, err});
		chk("unmapped data", 8'h00, rd);
		// Watchdog lock, counting while disabled, overflow and clear
		apb(1'b1, `IDX_WDT_CTRL, 8'h60);
		rdChk("wdt locked", `IDX_WDT_CTRL, 8'h40);
		apb(1'b1, `IDX_WDT_CTRL, 8'h80);
		rdChk("wdt unlocked", `IDX_WDT_CTRL, 8'hC0);
		apb(1'b1, `IDX_WDT_CTRL, 8'h21);
		rdChk("wdt relocked", `IDX_WDT_CTRL, 8'h20);
		// One overflow while disabled, then the counter wraps and climbs back to 250
		tick(1'b1, 8096);
		chk("nmi while disabled", 8'h00, 8'(nmiCount));
		apb(1'b1, `IDX_WDT_CTRL, 8'h80);
		apb(1'b1, `IDX_WDT_CTRL, 8'h60);
		tick(1'b1, 95);
		chk("nmi early", 8'h00, 8'(nmiCount));
		tick(1'b1, 1);
		chk("nmi overflow", 8'h01, 8'(nmiCount));
		apb(1'b1, `IDX_WDT_CTRL, 8'h01);
		tick(1'b1, 4095);
		tick(1'b0, 200);
		chk("nmi held off", 8'h01, 8'(nmiCount));
		tick(1'b1, 1);
		chk("nmi after clear", 8'h02, 8'(nmiCount));
		// Slow source selected: fast ticks must not advance the count
		apb(1'b1, `IDX_WDT_CTRL, 8'h80);
		apb(1'b1, `IDX_WDT_CTRL, 8'h41);
		rdChk("wdt slow", `IDX_WDT_CTRL, 8'h40);
		tick(1'b0, 4095);
		tick(1'b1, 200);
		chk("nmi slow early", 8'h02, 8'(nmiCount));
		tick(1'b0, 1);
		chk("nmi slow overflow", 8'h03, 8'(nmiCount));
		// Key selection and edge polarity
		apb(1'b1, `IDX_KEY_LOW_SEL, 8'h01);
		apb(1'b1, `IDX_KEY_LOW_POL, 8'h00);
		apb(1'b1, `IDX_KEY_HIGH_POL, 8'hFF);
		rdChk("high pol", `IDX_KEY_HIGH_POL, 8'h0F);
		keySet(8'h02, 4'hF);
		rdChk("unselected key", `IDX_KEY_FLAGS, 8'h00);
		keySet(8'h03, 4'hF);
		rdChk("selected rise", `IDX_KEY_FLAGS, 8'h08);
		apb(1'b1, `IDX_KEY_FLAGS, 8'h08);
		keySet(8'h02, 4'hF);
		rdChk("low fall ignored", `IDX_KEY_FLAGS, 8'h00);
		keySet(8'h02, 4'hE);
		rdChk("upper fall", `IDX_KEY_FLAGS, 8'h10);
		wrapUp();
	end
endmodule : testbench

`default_nettype wire
